// File: include/sfls_defs.svh
// Constants for the shift, flag and load/write execution unit
`ifndef SFLS_DEFS_SVH
`define SFLS_DEFS_SVH

// Bit positions inside flags_reg
`define SFLS_FLAG_C 0
`define SFLS_FLAG_Z 1
`define SFLS_FLAG_N 2
`define SFLS_FLAG_V 3
`define SFLS_FLAG_S 4
`define SFLS_FLAG_H 5
`define SFLS_FLAG_T 6
`define SFLS_FLAG_I 7

// Reset value of flags_reg
`define SFLS_FLAGS_RST 8'h00

// Cycle counts per instruction class
`define SFLS_CYC_SIMPLE 1
`define SFLS_CYC_MEM    2

`endif

// File: include/sfls_pkg.sv
// Types for the shift, flag and load/write execution unit
package sfls_pkg;

    typedef enum logic [4:0] {
        OP_NOP        = 5'h00,
        OP_LSHR       = 5'h01,
        OP_ROTL       = 5'h02,
        OP_ROTR       = 5'h03,
        OP_ASHR       = 5'h04,
        OP_SWAP       = 5'h05,
        OP_SBIT_SET   = 5'h06,
        OP_SBIT_CLR   = 5'h07,
        OP_TFLAG_GET  = 5'h08,
        OP_TFLAG_PUT  = 5'h09,
        OP_COPY       = 5'h0A,
        OP_PAIR_COPY  = 5'h0B,
        OP_IMM        = 5'h0C,
        OP_LOAD_IND   = 5'h0D,
        OP_LOAD_INC   = 5'h0E,
        OP_LOAD_DEC   = 5'h0F,
        OP_LOAD_DISP  = 5'h10,
        OP_LOAD_DIR   = 5'h11,
        OP_WRITE_IND  = 5'h12,
        OP_WRITE_INC  = 5'h13,
        OP_WRITE_DEC  = 5'h14,
        OP_WRITE_DISP = 5'h15
    } sfls_op_e;

    typedef enum logic [1:0] {
        PTR_X = 2'h0,
        PTR_Y = 2'h1,
        PTR_Z = 2'h2
    } sfls_ptr_e;

    typedef enum logic {
        S_IDLE = 1'b0,
        S_MEM  = 1'b1
    } sfls_state_e;

endpackage

// File: design/sfls_exec.sv
// Execution unit for shifts, flag moves and data memory transfers
//
// Behaviour
// - Rotate left moves bits up through C and sets Z C N V in one cycle.
// - Right shifts fill bit 7 with 0, C or bit 7 and set Z C N V at once.
// - Bit-to-transfer copies one source bit into T only, in one cycle.
// - Transfer-to-bit writes T into one target bit, flags kept, one cycle.
// - Each set form forces one of C N Z I S V T H high in one cycle.
// - Each clear form forces one of C N Z I S V T H low in one cycle.
// - Indirect load reads at the pointer, post-inc adds one, two cycles.
// - Pre-decrement load lowers the pointer, then reads there, two cycles.
// - Displacement load on Y or Z reads pointer plus offset, pointer kept.
// - Direct load reads the absolute address in two cycles, no flags.
// - Indirect write stores at pointer, post-inc adds one, two cycles.
// - Pre-decrement write lowers the pointer, stores there, two cycles.
// - Displacement write on Y or Z stores at pointer plus offset, pointer kept.
`timescale 1ns/1ps
`include "sfls_defs.svh"

module sfls_exec #(
    parameter int ADDR_W = 16,
    parameter int DISP_W = 6
) (
    // Clock and reset
    input  logic                 clk_i,
    input  logic                 rst_b_i,
    // Instruction issue
    input  logic                 valid_i,
    output logic                 ready_o,
    input  sfls_pkg::sfls_op_e   op_i,
    input  logic [4:0]           rd_idx_i,
    input  logic [7:0]           rd_val_i,
    input  logic [7:0]           rr_val_i,
    input  logic [7:0]           rr_hi_i,
    input  logic [7:0]           imm_i,
    input  logic [2:0]           bit_i,
    input  sfls_pkg::sfls_ptr_e  ptr_sel_i,
    input  logic [ADDR_W-1:0]    ptr_i,
    input  logic [DISP_W-1:0]    disp_i,
    input  logic [ADDR_W-1:0]    addr_i,
    output logic                 err_o,
    // Register file write
    output logic                 rf_we_o,
    output logic                 rf_pair_o,
    output logic [4:0]           rf_waddr_o,
    output logic [15:0]          rf_wdata_o,
    // Pointer pair write
    output logic                 ptr_we_o,
    output sfls_pkg::sfls_ptr_e  ptr_wsel_o,
    output logic [ADDR_W-1:0]    ptr_wdata_o,
    // Data memory
    output logic                 mem_re_o,
    output logic                 mem_we_o,
    output logic [ADDR_W-1:0]    mem_addr_o,
    output logic [7:0]           mem_wdata_o,
    input  logic [7:0]           mem_rdata_i,
    // Status
    output logic [7:0]           flags_o
);

    if (ADDR_W < 8 || ADDR_W > 16 || DISP_W < 1 || DISP_W >= ADDR_W) begin : g_chk
        $error("sfls_exec: unsupported address or displacement width");
    end

    sfls_pkg::sfls_state_e state_reg,     state_next;
    sfls_pkg::sfls_ptr_e   ptr_wsel_reg,  ptr_wsel_next;
    logic [7:0]            flags_reg,     flags_next;
    logic                  rf_we_reg,     rf_we_next;
    logic                  rf_pair_reg,   rf_pair_next;
    logic [4:0]            rf_waddr_reg,  rf_waddr_next;
    logic [15:0]           rf_wdata_reg,  rf_wdata_next;
    logic                  ptr_we_reg,    ptr_we_next;
    logic [ADDR_W-1:0]     ptr_wdata_reg, ptr_wdata_next;
    logic                  mem_re_reg,    mem_re_next;
    logic                  mem_we_reg,    mem_we_next;
    logic [ADDR_W-1:0]     mem_addr_reg,  mem_addr_next;
    logic [7:0]            mem_wdata_reg, mem_wdata_next;
    logic                  err_reg,       err_next;
    logic [7:0]            bmask_w;
    logic                  tbit_w;

    assign bmask_w = 8'h01 << bit_i;
    assign tbit_w  = rr_val_i[bit_i];

    // One memory op occupies two issue slots
    assign ready_o     = (state_reg == sfls_pkg::S_IDLE);
    assign err_o       = err_reg;
    assign rf_we_o     = rf_we_reg;
    assign rf_pair_o   = rf_pair_reg;
    assign rf_waddr_o  = rf_waddr_reg;
    assign rf_wdata_o  = rf_wdata_reg;
    assign ptr_we_o    = ptr_we_reg;
    assign ptr_wsel_o  = ptr_wsel_reg;
    assign ptr_wdata_o = ptr_wdata_reg;
    assign mem_re_o    = mem_re_reg;
    assign mem_we_o    = mem_we_reg;
    assign mem_addr_o  = mem_addr_reg;
    assign mem_wdata_o = mem_wdata_reg;
    assign flags_o     = flags_reg;

    always_comb begin
        logic [7:0] res;
        logic       cout;
        logic       shift_wr;
        logic       mem_go;
        logic       is_wr;
        res            = 8'h00;
        cout           = 1'b0;
        shift_wr       = 1'b0;
        mem_go         = 1'b0;
        is_wr          = 1'b0;
        state_next     = state_reg;
        flags_next     = flags_reg;
        rf_we_next     = 1'b0;
        rf_pair_next   = 1'b0;
        rf_waddr_next  = rf_waddr_reg;
        rf_wdata_next  = rf_wdata_reg;
        ptr_we_next    = 1'b0;
        ptr_wsel_next  = ptr_wsel_reg;
        ptr_wdata_next = ptr_wdata_reg;
        mem_re_next    = 1'b0;
        mem_we_next    = 1'b0;
        mem_addr_next  = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        err_next       = 1'b0;
        if (state_reg == sfls_pkg::S_MEM) begin
            state_next = sfls_pkg::S_IDLE;
            if (mem_re_reg) begin
                rf_we_next    = 1'b1;
                rf_wdata_next = {8'h00, mem_rdata_i};
            end
        end else if (valid_i) begin
            rf_waddr_next = rd_idx_i;
            ptr_wsel_next = ptr_sel_i;
            case (op_i)
                sfls_pkg::OP_ROTL: begin
                    {cout, res} = {rd_val_i, flags_reg[`SFLS_FLAG_C]};
                    shift_wr    = 1'b1;
                end
                sfls_pkg::OP_LSHR: begin
                    {res, cout} = {1'b0, rd_val_i};
                    shift_wr    = 1'b1;
                end
                sfls_pkg::OP_ROTR: begin
                    {res, cout} = {flags_reg[`SFLS_FLAG_C], rd_val_i};
                    shift_wr    = 1'b1;
                end
                sfls_pkg::OP_ASHR: begin
                    {res, cout} = {rd_val_i[7], rd_val_i};
                    shift_wr    = 1'b1;
                end
                sfls_pkg::OP_SWAP: begin
                    rf_we_next    = 1'b1;
                    rf_wdata_next = {8'h00, rd_val_i[3:0], rd_val_i[7:4]};
                end
                sfls_pkg::OP_SBIT_SET: begin
                    flags_next = flags_reg | bmask_w;
                end
                sfls_pkg::OP_SBIT_CLR: begin
                    flags_next = flags_reg & ~bmask_w;
                end
                sfls_pkg::OP_TFLAG_GET: begin
                    flags_next[`SFLS_FLAG_T] = tbit_w;
                end
                sfls_pkg::OP_TFLAG_PUT: begin
                    rf_we_next    = 1'b1;
                    rf_wdata_next = {8'h00, (rd_val_i & ~bmask_w) |
                        ({8{flags_reg[`SFLS_FLAG_T]}} & bmask_w)};
                end
                sfls_pkg::OP_COPY: begin
                    rf_we_next    = 1'b1;
                    rf_wdata_next = {8'h00, rr_val_i};
                end
                sfls_pkg::OP_PAIR_COPY: begin
                    rf_we_next    = 1'b1;
                    rf_pair_next  = 1'b1;
                    rf_wdata_next = {rr_hi_i, rr_val_i};
                end
                sfls_pkg::OP_IMM: begin
                    rf_we_next    = 1'b1;
                    rf_wdata_next = {8'h00, imm_i};
                end
                sfls_pkg::OP_LOAD_IND, sfls_pkg::OP_WRITE_IND: begin
                    mem_go        = 1'b1;
                    mem_addr_next = ptr_i;
                end
                sfls_pkg::OP_LOAD_INC, sfls_pkg::OP_WRITE_INC: begin
                    mem_go         = 1'b1;
                    mem_addr_next  = ptr_i;
                    ptr_we_next    = 1'b1;
                    ptr_wdata_next = ptr_i + ADDR_W'(1);
                end
                sfls_pkg::OP_LOAD_DEC, sfls_pkg::OP_WRITE_DEC: begin
                    mem_go         = 1'b1;
                    mem_addr_next  = ptr_i - ADDR_W'(1);
                    ptr_we_next    = 1'b1;
                    ptr_wdata_next = ptr_i - ADDR_W'(1);
                end
                sfls_pkg::OP_LOAD_DISP, sfls_pkg::OP_WRITE_DISP: begin
                    if (ptr_sel_i == sfls_pkg::PTR_X) begin
                        err_next = 1'b1;
                    end else begin
                        mem_go        = 1'b1;
                        mem_addr_next = ptr_i + ADDR_W'(disp_i);
                    end
                end
                sfls_pkg::OP_LOAD_DIR: begin
                    mem_go        = 1'b1;
                    mem_addr_next = addr_i;
                end
                default: begin
                    err_next = (op_i != sfls_pkg::OP_NOP);
                end
            endcase
            if (shift_wr) begin
                rf_we_next               = 1'b1;
                rf_wdata_next            = {8'h00, res};
                flags_next[`SFLS_FLAG_Z] = (res == 8'h00);
                flags_next[`SFLS_FLAG_C] = cout;
                flags_next[`SFLS_FLAG_N] = res[7];
                flags_next[`SFLS_FLAG_V] = res[7] ^ cout;
            end
            is_wr = (op_i == sfls_pkg::OP_WRITE_IND) ||
                    (op_i == sfls_pkg::OP_WRITE_INC) ||
                    (op_i == sfls_pkg::OP_WRITE_DEC) ||
                    (op_i == sfls_pkg::OP_WRITE_DISP);
            if (mem_go) begin
                state_next     = sfls_pkg::S_MEM;
                mem_re_next    = !is_wr;
                mem_we_next    = is_wr;
                mem_wdata_next = rr_val_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg     <= sfls_pkg::S_IDLE;
            flags_reg     <= `SFLS_FLAGS_RST;
            rf_we_reg     <= 1'b0;
            rf_pair_reg   <= 1'b0;
            rf_waddr_reg  <= 5'h00;
            rf_wdata_reg  <= 16'h0000;
            ptr_we_reg    <= 1'b0;
            ptr_wsel_reg  <= sfls_pkg::PTR_X;
            ptr_wdata_reg <= '0;
            mem_re_reg    <= 1'b0;
            mem_we_reg    <= 1'b0;
            mem_addr_reg  <= '0;
            mem_wdata_reg <= 8'h00;
            err_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            flags_reg     <= flags_next;
            rf_we_reg     <= rf_we_next;
            rf_pair_reg   <= rf_pair_next;
            rf_waddr_reg  <= rf_waddr_next;
            rf_wdata_reg  <= rf_wdata_next;
            ptr_we_reg    <= ptr_we_next;
            ptr_wsel_reg  <= ptr_wsel_next;
            ptr_wdata_reg <= ptr_wdata_next;
            mem_re_reg    <= mem_re_next;
            mem_we_reg    <= mem_we_next;
            mem_addr_reg  <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
            err_reg       <= err_next;
        end
    end

    // Checks
    logic acc;
    assign acc = valid_i && ready_o;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    rotl_result_a: assert property (acc && op_i == sfls_pkg::OP_ROTL |=>
        rf_we_o && rf_wdata_o[7:0] ==
        {$past(rd_val_i[6:0]), $past(flags_o[`SFLS_FLAG_C])} &&
        flags_o[`SFLS_FLAG_C] == $past(rd_val_i[7]))
        else $error("rotate left result or carry wrong");

    rshift_fill_a: assert property (acc && (op_i == sfls_pkg::OP_LSHR ||
        op_i == sfls_pkg::OP_ASHR) |=>
        rf_wdata_o[6:0] == $past(rd_val_i[7:1]) &&
        flags_o[`SFLS_FLAG_C] == $past(rd_val_i[0]) &&
        flags_o[`SFLS_FLAG_N] == rf_wdata_o[7] &&
        flags_o[`SFLS_FLAG_Z] == (rf_wdata_o[7:0] == 8'h00) &&
        flags_o[`SFLS_FLAG_V] == (rf_wdata_o[7] ^ $past(rd_val_i[0]))
        && rf_wdata_o[7] == ($past(op_i) == sfls_pkg::OP_ASHR &&
        $past(rd_val_i[7])))
        else $error("right shift result or flags wrong");

    tflag_get_a: assert property (acc && op_i == sfls_pkg::OP_TFLAG_GET |=>
        flags_o[`SFLS_FLAG_T] == $past(rr_val_i[bit_i]) &&
        ((flags_o ^ $past(flags_o)) & 8'hBF) == 8'h00)
        else $error("bit to T wrong or other flag moved");

    tflag_put_a: assert property (acc && op_i == sfls_pkg::OP_TFLAG_PUT |=>
        rf_we_o && $stable(flags_o) &&
        ((rf_wdata_o[7:0] ^ $past(rd_val_i)) &
        ~(8'h01 << $past(bit_i))) == 8'h00 &&
        ((rf_wdata_o[7:0] >> $past(bit_i)) & 8'h01) ==
        {7'h00, flags_o[`SFLS_FLAG_T]})
        else $error("T to bit wrong");

    sbit_set_a: assert property (acc && op_i == sfls_pkg::OP_SBIT_SET |=>
        flags_o == ($past(flags_o) | (8'h01 << $past(bit_i))) && !rf_we_o)
        else $error("flag assert wrong");

    sbit_clr_a: assert property (acc && op_i == sfls_pkg::OP_SBIT_CLR |=>
        flags_o == ($past(flags_o) & ~(8'h01 << $past(bit_i))))
        else $error("flag deassert wrong");

    load_inc_a: assert property (acc && op_i == sfls_pkg::OP_LOAD_INC |=>
        mem_re_o && !ready_o && mem_addr_o == $past(ptr_i) && ptr_we_o &&
        ptr_wdata_o == $past(ptr_i) + ADDR_W'(1) ##1
        rf_we_o && ready_o && rf_wdata_o[7:0] == $past(mem_rdata_i))
        else $error("post-increment load wrong");

    load_dec_a: assert property (acc && op_i == sfls_pkg::OP_LOAD_DEC |=>
        mem_re_o && mem_addr_o == $past(ptr_i) - ADDR_W'(1) &&
        ptr_wdata_o == mem_addr_o ##1 rf_we_o)
        else $error("pre-decrement load wrong");

    load_disp_a: assert property (acc && op_i == sfls_pkg::OP_LOAD_DISP &&
        ptr_sel_i != sfls_pkg::PTR_X |=> mem_re_o && !ptr_we_o &&
        mem_addr_o - $past(ptr_i) == ADDR_W'($past(disp_i)))
        else $error("displacement load wrong");

    disp_x_a: assert property (acc && op_i == sfls_pkg::OP_LOAD_DISP &&
        ptr_sel_i == sfls_pkg::PTR_X |=> err_o && !mem_re_o && ready_o)
        else $error("X displacement not refused");

    load_dir_a: assert property (acc && op_i == sfls_pkg::OP_LOAD_DIR |=>
        mem_re_o && mem_addr_o == $past(addr_i) ##1 rf_we_o && $stable(flags_o))
        else $error("direct load wrong");

    write_inc_a: assert property (acc && op_i == sfls_pkg::OP_WRITE_INC |=>
        mem_we_o && mem_wdata_o == $past(rr_val_i) &&
        mem_addr_o == $past(ptr_i) && ptr_wdata_o == $past(ptr_i) + ADDR_W'(1)
        ##1 ready_o && !mem_we_o && !rf_we_o)
        else $error("post-increment write wrong");

    write_dec_a: assert property (acc && op_i == sfls_pkg::OP_WRITE_DEC |=>
        mem_we_o && ptr_we_o && mem_addr_o == $past(ptr_i) - ADDR_W'(1))
        else $error("pre-decrement write wrong");

    write_disp_a: assert property (acc && op_i == sfls_pkg::OP_WRITE_DISP &&
        ptr_sel_i != sfls_pkg::PTR_X |=> mem_we_o && !ptr_we_o &&
        $stable(flags_o) && mem_addr_o - $past(ptr_i) == ADDR_W'($past(disp_i)))
        else $error("displacement write wrong");

    swap_nib_a: assert property (acc && op_i == sfls_pkg::OP_SWAP |=>
        rf_we_o && $stable(flags_o) &&
        rf_wdata_o[7:0] == {$past(rd_val_i[3:0]), $past(rd_val_i[7:4])})
        else $error("nibble exchange wrong");

    pair_copy_a: assert property (acc && op_i == sfls_pkg::OP_PAIR_COPY |=>
        rf_we_o && rf_pair_o && $stable(flags_o) &&
        rf_wdata_o == {$past(rr_hi_i), $past(rr_val_i)})
        else $error("pair copy wrong");

endmodule

// File: tb/sfls_mem_model.sv
// Data memory partner with same-cycle read data
`timescale 1ns/1ps

module sfls_mem_model #(
    parameter int ADDR_W = 16
) (
    // Clock
    input  wire logic              clk_i,
    // Memory strobes and address
    input  wire logic              mem_re_i,
    input  wire logic              mem_we_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    input  wire logic [7:0]        mem_wdata_i,
    // Read data
    output logic      [7:0]        mem_rdata_o
);
    // Only 256 bytes: upper address bits alias, enough for the bench
    logic [7:0] mem [256];
    logic [7:0] last_q;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
        last_q = 8'h00;
    end

    // Outside a read the bus shows the inverse of the last byte, so a
    // sample taken a cycle late cannot match by luck
    assign mem_rdata_o = mem_re_i ? mem[mem_addr_i[7:0]] : ~last_q;

    always @(posedge clk_i) begin
        if (mem_re_i) begin
            last_q <= mem[mem_addr_i[7:0]];
        end
        if (mem_we_i) begin
            mem[mem_addr_i[7:0]] <= mem_wdata_i;
        end
    end
endmodule

// File: tb/sfls_exec_tb.sv
// Self-checking bench for the shift, flag and memory transfer unit
`timescale 1ns/1ps
`include "sfls_defs.svh"

`define CHK(nm, ex, got) begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
        error_cnt++; \
        $display("MISMATCH %s exp %h got %h", nm, ex, got); \
    end \
end

module sfls_exec_tb;
    logic                 clk_i, rst_b_i, valid_i;
    sfls_pkg::sfls_op_e   op_i;
    logic [4:0]           rd_idx_i, rf_waddr_o;
    logic [7:0]           rd_val_i, rr_val_i, rr_hi_i, imm_i;
    logic [2:0]           bit_i;
    sfls_pkg::sfls_ptr_e  ptr_sel_i, ptr_wsel_o;
    logic [15:0]          ptr_i, addr_i, rf_wdata_o, ptr_wdata_o;
    logic [15:0]          mem_addr_o;
    logic [5:0]           disp_i;
    logic                 ready_o, err_o, rf_we_o, rf_pair_o;
    logic                 ptr_we_o, mem_re_o, mem_we_o;
    logic [7:0]           mem_wdata_o, mem_rdata_i, flags_o, fl;
    int                   error_cnt, num_checks;

    sfls_exec u_sfls_exec (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .valid_i(valid_i),
        .ready_o(ready_o), .op_i(op_i), .rd_idx_i(rd_idx_i),
        .rd_val_i(rd_val_i), .rr_val_i(rr_val_i), .rr_hi_i(rr_hi_i),
        .imm_i(imm_i), .bit_i(bit_i), .ptr_sel_i(ptr_sel_i),
        .ptr_i(ptr_i), .disp_i(disp_i), .addr_i(addr_i),
        .err_o(err_o), .rf_we_o(rf_we_o), .rf_pair_o(rf_pair_o),
        .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o),
        .ptr_we_o(ptr_we_o), .ptr_wsel_o(ptr_wsel_o),
        .ptr_wdata_o(ptr_wdata_o), .mem_re_o(mem_re_o),
        .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .flags_o(flags_o)
    );

    sfls_mem_model u_sfls_mem_model (
        .clk_i(clk_i), .mem_re_i(mem_re_o), .mem_we_i(mem_we_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic step;
        @(posedge clk_i);
        #1;
    endtask

    // Leading step keeps valid from being driven twice in one time step
    task automatic go(input sfls_pkg::sfls_op_e op);
        step();
        op_i = op;
        valid_i = 1'b1;
        step();
        valid_i = 1'b0;
    endtask

    task automatic t_flag(input sfls_pkg::sfls_op_e op, input int b);
        bit_i = 3'(b);
        go(op);
        fl[b] = (op == sfls_pkg::OP_SBIT_SET);
        `CHK("flags_set_clr", fl, flags_o)
    endtask

    task automatic t_shift(input sfls_pkg::sfls_op_e op,
                           input logic [7:0] v);
        logic [7:0] r;
        logic       c;
        c = v[0];
        r = {1'b0, v[7:1]};
        if (op == sfls_pkg::OP_ROTL) begin
            r = {v[6:0], fl[`SFLS_FLAG_C]};
            c = v[7];
        end
        if (op == sfls_pkg::OP_ROTR) r = {fl[`SFLS_FLAG_C], v[7:1]};
        if (op == sfls_pkg::OP_ASHR) r = {v[7], v[7:1]};
        if (op == sfls_pkg::OP_SWAP) r = {v[3:0], v[7:4]};
        rd_val_i = v;
        go(op);
        if (op != sfls_pkg::OP_SWAP) begin
            fl[`SFLS_FLAG_C] = c;
            fl[`SFLS_FLAG_Z] = (r == 8'h00);
            fl[`SFLS_FLAG_N] = r[7];
            fl[`SFLS_FLAG_V] = r[7] ^ c;
        end
        `CHK("shift_we", 1'b1, rf_we_o)
        `CHK("shift_data", {8'h00, r}, rf_wdata_o)
        `CHK("shift_flags", fl, flags_o)
    endtask

    task automatic t_tbit;
        rr_val_i = 8'h20;
        for (int b = 5; b >= 4; b--) begin
            bit_i = 3'(b);
            go(sfls_pkg::OP_TFLAG_GET);
            fl[`SFLS_FLAG_T] = (b == 5);
            `CHK("bit_to_t", fl, flags_o)
        end
        rd_val_i = 8'hFF;
        bit_i = 3'd2;
        go(sfls_pkg::OP_TFLAG_PUT);
        `CHK("t_to_bit0", 16'h00FB, rf_wdata_o)
        t_flag(sfls_pkg::OP_SBIT_SET, `SFLS_FLAG_T);
        rd_val_i = 8'h00;
        bit_i = 3'd7;
        go(sfls_pkg::OP_TFLAG_PUT);
        `CHK("t_to_bit1", 16'h0080, rf_wdata_o)
        `CHK("t_to_bit_fl", fl, flags_o)
    endtask

    task automatic t_copy;
        rd_idx_i = 5'd6;
        rr_val_i = 8'h5A;
        rr_hi_i = 8'h12;
        imm_i = 8'hC3;
        go(sfls_pkg::OP_COPY);
        `CHK("copy", 18'h2_005A, {rf_we_o, rf_pair_o, rf_wdata_o})
        go(sfls_pkg::OP_PAIR_COPY);
        `CHK("pair", 22'h26_125A, {rf_pair_o, rf_waddr_o, rf_wdata_o})
        go(sfls_pkg::OP_IMM);
        `CHK("imm", 16'h00C3, rf_wdata_o)
        `CHK("copy_fl", fl, flags_o)
    endtask

    task automatic t_mem(input sfls_pkg::sfls_op_e op, input int p);
        logic [15:0] pv, a, np;
        logic        wr, upd, bad, dsp;
        pv = 16'h0100 + 16'(p) * 16'h0040;
        wr = (op >= sfls_pkg::OP_WRITE_IND);
        dsp = op inside {sfls_pkg::OP_LOAD_DISP, sfls_pkg::OP_WRITE_DISP};
        upd = op inside {sfls_pkg::OP_LOAD_INC, sfls_pkg::OP_LOAD_DEC,
                         sfls_pkg::OP_WRITE_INC, sfls_pkg::OP_WRITE_DEC};
        bad = dsp && (p == 0);
        a = dsp ? pv + {10'h000, disp_i} : pv;
        np = pv + 16'h0001;
        if (op inside {sfls_pkg::OP_LOAD_DEC, sfls_pkg::OP_WRITE_DEC}) begin
            a = pv - 16'h0001;
            np = a;
        end
        if (op == sfls_pkg::OP_LOAD_DIR) a = addr_i;
        ptr_sel_i = sfls_pkg::sfls_ptr_e'(p);
        ptr_i = pv;
        rr_val_i = pv[7:0] ^ 8'h3C;
        go(op);
        `CHK("err", bad, err_o)
        `CHK("strobes", {!wr && !bad, wr && !bad}, {mem_re_o, mem_we_o})
        `CHK("ptr_we", upd, ptr_we_o)
        if (!bad) begin
            `CHK("mem_addr", a, mem_addr_o)
            `CHK("busy", 1'b0, ready_o)
        end
        if (upd) begin
            `CHK("ptr_new", np, ptr_wdata_o)
            `CHK("ptr_sel", ptr_sel_i, ptr_wsel_o)
        end
        if (wr && !bad) `CHK("wdata", rr_val_i, mem_wdata_o)
        step();
        `CHK("ld_we", !wr && !bad, rf_we_o)
        if (!wr && !bad) begin
            `CHK("ld_data", {8'h00, a[7:0] ^ 8'hA5}, rf_wdata_o)
            `CHK("ld_idx", rd_idx_i, rf_waddr_o)
        end
        `CHK("mem_fl", fl, flags_o)
        `CHK("idle", 1'b1, ready_o)
    endtask

    initial begin
        sfls_pkg::sfls_op_e sh[5];
        sh = '{sfls_pkg::OP_LSHR, sfls_pkg::OP_ROTL, sfls_pkg::OP_ROTR,
               sfls_pkg::OP_ASHR, sfls_pkg::OP_SWAP};
        error_cnt = 0;
        num_checks = 0;
        {valid_i, rd_idx_i, rd_val_i, rr_val_i, rr_hi_i, imm_i} = '0;
        {bit_i, ptr_i, disp_i, addr_i} = '0;
        op_i = sfls_pkg::OP_NOP;
        ptr_sel_i = sfls_pkg::PTR_X;
        fl = `SFLS_FLAGS_RST;
        rst_b_i = 1'b0;
        repeat (16) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        `CHK("rst_flags", fl, flags_o)
        for (int b = 0; b < 8; b++) t_flag(sfls_pkg::OP_SBIT_SET, b);
        for (int b = 0; b < 8; b++) t_flag(sfls_pkg::OP_SBIT_CLR, b);
        t_flag(sfls_pkg::OP_SBIT_SET, `SFLS_FLAG_S);
        foreach (sh[i]) t_shift(sh[i], 8'h81);
        t_flag(sfls_pkg::OP_SBIT_CLR, `SFLS_FLAG_C);
        foreach (sh[i]) t_shift(sh[i], 8'h01);
        t_flag(sfls_pkg::OP_SBIT_SET, `SFLS_FLAG_C);
        foreach (sh[i]) t_shift(sh[i], 8'h80);
        t_tbit();
        t_copy();
        // Loads first, so the model still holds its seeded pattern
        disp_i = 6'h3F;
        addr_i = 16'h1234;
        t_mem(sfls_pkg::OP_LOAD_DIR, 0);
        for (int p = 0; p < 3; p++) begin
            for (int o = 13; o <= 16; o++) t_mem(sfls_pkg::sfls_op_e'(o), p);
        end
        for (int p = 0; p < 3; p++) begin
            for (int o = 18; o <= 21; o++) t_mem(sfls_pkg::sfls_op_e'(o), p);
        end
        tally_and_finish();
    end

    initial begin
        #20000;
        error_cnt++;
        $display("Watchdog expired before the tests ended");
        tally_and_finish();
    end
endmodule
